/* src/clk_divider.sv */
// Serial clock divider: edge pulses for a period of divisor plus one, or of four for divisors below three.
// Assumes one clock domain and an enable held for a whole transfer.
`timescale 1ns/1ns
`default_nettype none
`include "spi_baud_map.svh"

module clk_divider (
    input wire logic pclk,               // Peripheral clock
    input wire logic presetn,            // Async reset, active low
    input wire logic run,                // Count while high
    input wire logic [6:0] div,          // Divider value
    output logic rise_p,                 // Serial clock goes high
    output logic fall_p                  // Serial clock goes low
);
    logic [7:0] cnt_r;   // Cycle within the period
    logic [7:0] cnt_nxt; // Next count
    logic [7:0] period;  // Cycles per serial clock period
    logic [7:0] half;    // Cycles of the low phase

    // Small divisors would give too short a phase, so they clamp
    assign period = (div < `DIV_MIN) ? `DIV_SLOW_PERIOD
                                     : ({1'b0, div} + 8'h01);
    assign half = period >> 1;
    assign rise_p = run && (cnt_r == half - 8'h01);
    assign fall_p = run && (cnt_r == period - 8'h01);
    assign cnt_nxt = fall_p ? 8'h00 : cnt_r + 8'h01;

    // Counter restarts at zero whenever the divider is idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 8'h00;
        end else if (!run) begin
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule // clk_divider

`default_nettype wire

/* src/spi_baud_and_rx_mirror.sv */
// Bit-rate generator and receive buffer with its mirror, on APB.
// Assumes pins synchronous to pclk and a serial input set up before
// each rising serial clock edge.
//
// Functional notes
// - Divider top bit reads zero, ignores writes
// - Low seven divider bits set master rate
// - One data bit per serial clock period
// - Slave takes serial clock from pin
// - Slave serial clock ignores divider contents
// - Master generates and drives serial clock
// - Divider 3..127 gives clock over value+1
// - Divider 0..2 gives clock over four
// - Mirror is second address of buffer
// - Mirror read keeps character flag
// - Complete character loads buffer, sets flag
// - Buffer read clears character flag
// - Flag set after last bit done
// - Data shifted MSB first, right-justified
//
// Local design decision: the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "spi_baud_map.svh"

module spi_baud_and_rx_mirror
    import spi_baud_pkg::*;
(
    input wire logic pclk,                 // Peripheral clock
    input wire logic presetn,              // Async reset, active low
    input wire logic psel,                 // APB select
    input wire logic penable,              // APB access phase
    input wire logic pwrite,               // APB write
    input wire logic [`ADDR_W-1:0] paddr,  // APB byte address
    input wire logic [31:0] pwdata,        // APB write data
    output logic [31:0] prdata,            // APB read data
    output logic pready,                   // APB ready
    output logic pslverr,                  // APB error
    input wire logic sclk_in,              // Serial clock pin level
    output logic sclk_out,                 // Serial clock pin drive
    output logic sclk_oe,                  // Serial clock pin enable
    input wire logic sdi,                  // Serial data in
    output logic irq                       // Level interrupt
);
    // Register state
    logic [6:0] div_r;             // Bit-rate divider
    ctrl_t ctrl_r;                 // Mode and length
    logic [15:0] rxbuf_r;          // Receive buffer
    logic [15:0] shift_r;          // Receive shifter
    logic flag_r;                  // Character complete
    logic [`EV_W-1:0] ists_r;      // Sticky events
    logic [`EV_W-1:0] ien_r;       // Event enables
    xfer_t st_r;                   // Sequencer state
    logic [3:0] bits_r;            // Bits taken so far
    logic tail_r; // Last bit taken, closing fall still due
    logic pin_d_r;                 // Previous serial clock pin level
    logic [31:0] prdata_r;         // Read data
    logic pready_r;                // Access answered
    logic pslverr_r;               // Unmapped access
    logic sclk_r;                  // Driven serial clock
    logic oe_r;                    // Pin enable
    logic irq_r;                   // Interrupt level

    // Bus decode
    logic acc_go;      // Access phase awaiting answer
    logic acc_done;    // Access completes this edge
    logic wr_done;     // Write takes effect
    logic rd_done;     // Read takes effect
    logic [15:0] idx;  // Register index from address
    logic aligned;     // Low address bits zero
    logic hit_div;
    logic hit_mir;
    logic hit_buf;
    logic hit_ctl;
    logic hit_sts;
    logic hit_ists;
    logic hit_iclr;
    logic hit_ien;
    logic mapped;
    logic [31:0] rd_mux;

    assign acc_go = psel && penable && !pready_r;
    assign acc_done = psel && penable && pready_r;
    assign wr_done = acc_done && pwrite && !pslverr_r;
    assign rd_done = acc_done && !pwrite && !pslverr_r;
    assign idx = paddr[`ADDR_W-1:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign hit_div = aligned && (idx == `IDX_DIVIDER);
    assign hit_mir = aligned && (idx == `IDX_MIRROR);
    assign hit_buf = aligned && (idx == `IDX_RXBUF);
    assign hit_ctl = aligned && (idx == `IDX_CTRL);
    assign hit_sts = aligned && (idx == `IDX_STATUS);
    assign hit_ists = aligned && (idx == `IDX_INT_STS);
    assign hit_iclr = aligned && (idx == `IDX_INT_CLR);
    assign hit_ien = aligned && (idx == `IDX_INT_EN);
    assign mapped = hit_div | hit_mir | hit_buf | hit_ctl | hit_sts
                  | hit_ists | hit_iclr | hit_ien;

    // Read selection; buffer and mirror share one store
    assign rd_mux = hit_div ? {25'h0, div_r} :
                    (hit_mir | hit_buf) ? {16'h0, rxbuf_r} :
                    hit_ctl ? {24'h0, ctrl_r.len_m1, 3'h0,
                               ctrl_r.master} :
                    hit_sts ? {25'h0, flag_r, 6'h0} :
                    hit_ists ? {30'h0, ists_r} :
                    hit_ien ? {30'h0, ien_r} : 32'h0;

    // Every access is answered after one wait cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= acc_go;
            prdata_r <= (acc_go && !pwrite) ? rd_mux : 32'h0;
            pslverr_r <= acc_go && !mapped;
        end
    end

    // Control writes
    logic start_w;  // Master start request
    // The mode bit is taken from the same write, since ctrl_r still
    // holds the old mode at the edge where the start lands
    assign start_w = wr_done && hit_ctl && pwdata[`CTRL_START]
                     && pwdata[`CTRL_MASTER];

    // Only the low seven bits are stored, so bit 7 cannot be set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= `DIV_RST;
            ctrl_r <= '{len_m1: `LEN_RST, master: 1'b0};
            ien_r <= '0;
        end else begin
            if (wr_done && hit_div) begin
                div_r <= pwdata[`DIV_W-1:0];
            end
            if (wr_done && hit_ctl) begin
                ctrl_r.master <= pwdata[`CTRL_MASTER];
                ctrl_r.len_m1 <= pwdata[`CTRL_LEN_HI:`CTRL_LEN_LO];
            end
            if (wr_done && hit_ien) begin
                ien_r <= pwdata[`EV_W-1:0];
            end
        end
    end

    // Serial clock edges
    logic run;       // Master divider active
    logic div_rise;  // Divider rising edge
    logic div_fall;  // Divider falling edge
    logic pin_rise;  // Pin rising edge seen
    logic take;      // Sample a data bit now
    logic last_bit;  // Current bit ends character
    logic done_ev;   // Character complete
    logic [15:0] shift_nxt;
    logic [3:0] bits_nxt;

    assign run = ctrl_r.master && (st_r == X_RUN);

    clk_divider u_div (
        .pclk(pclk),
        .presetn(presetn),
        .run(run),
        .div(div_r),
        .rise_p(div_rise),
        .fall_p(div_fall)
    );

    // Pin edges are only seen reliably at a quarter rate or slower
    assign pin_rise = sclk_in && !pin_d_r;
    assign take = ctrl_r.master ? div_rise : pin_rise;
    assign last_bit = (bits_r == ctrl_r.len_m1);
    // Master ends on the closing fall; slave on the last rise
    assign done_ev = ctrl_r.master ? (div_fall && tail_r
                                      && run)
                                   : (take && last_bit);
    // MSB arrives first and ends in the low bits
    assign shift_nxt = {shift_r[14:0], sdi};
    assign bits_nxt = bits_r + 4'h1;

    // Pin level history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_d_r <= 1'b0;
        end else begin
            pin_d_r <= sclk_in;
        end
    end

    // Receive sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= X_IDLE;
            bits_r <= 4'h0;
            shift_r <= `WORD_RST;
            tail_r <= 1'b0;
        end else begin
            case (st_r)
                X_IDLE: begin
                    // Master waits for start; slave starts at an edge
                    if (start_w) begin
                        st_r <= X_RUN;
                        bits_r <= 4'h0;
                        shift_r <= `WORD_RST;
                    end else if (!ctrl_r.master && take) begin
                        // First slave bit lands here; a one-bit
                        // character is already complete
                        st_r <= last_bit ? X_IDLE : X_RUN;
                        bits_r <= last_bit ? 4'h0 : 4'h1;
                        shift_r <= {15'h0, sdi};
                    end
                    tail_r <= 1'b0;
                end
                X_RUN: begin
                    if (take) begin
                        shift_r <= shift_nxt;
                        bits_r <= last_bit ? bits_r : bits_nxt;
                        // Count saturates, so remember the final take
                        tail_r <= last_bit;
                    end
                    if (done_ev) begin
                        st_r <= X_IDLE;
                        bits_r <= 4'h0;
                        tail_r <= 1'b0;
                    end
                end
                default: begin
                    st_r <= X_IDLE;
                end
            endcase
        end
    end

    // Completed character word as seen by the buffer
    logic [15:0] char_w;
    assign char_w = (st_r == X_IDLE) ? {15'h0, sdi} : shift_nxt;

    // Buffer and flag; a completion beats a clearing read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxbuf_r <= `WORD_RST;
            flag_r <= 1'b0;
        end else if (done_ev) begin
            rxbuf_r <= ctrl_r.master ? shift_r : char_w;
            flag_r <= 1'b1;
        end else if (rd_done && hit_buf) begin
            flag_r <= 1'b0;
        end
    end

    // Events: character done, and overrun of an unread character
    logic [`EV_W-1:0] ev;
    logic [`EV_W-1:0] clr;
    assign ev[`EV_CHAR] = done_ev;
    assign ev[`EV_OVR] = done_ev && flag_r;
    assign clr = (wr_done && hit_iclr) ? pwdata[`EV_W-1:0] : '0;

    // Sticky status; set wins over a write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ists_r <= '0;
            irq_r <= 1'b0;
        end else begin
            ists_r <= (ists_r & ~clr) | ev;
            irq_r <= |(((ists_r & ~clr) | ev) & ien_r);
        end
    end

    // Pin drive: master owns the clock, slave only listens
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_r <= 1'b0;
            oe_r <= 1'b0;
        end else begin
            oe_r <= ctrl_r.master;
            if (!run) begin
                sclk_r <= 1'b0;
            end else if (div_rise) begin
                sclk_r <= 1'b1;
            end else if (div_fall) begin
                sclk_r <= 1'b0;
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign sclk_out = sclk_r;
    assign sclk_oe = oe_r;
    assign irq = irq_r;

    // Helper: cycles since last master rising edge
    logic [7:0] gap_r;
    logic seen_r;
    logic [7:0] exp_per;
    assign exp_per = (div_r < `DIV_MIN) ? `DIV_SLOW_PERIOD
                                        : ({1'b0, div_r} + 8'h01);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_r <= 8'h00;
            seen_r <= 1'b0;
        end else begin
            gap_r <= div_rise ? 8'h01 : gap_r + 8'h01;
            seen_r <= run && (seen_r || div_rise);
        end
    end

    AST_DIV_TOP: assert property (@(posedge pclk) disable iff (!presetn)
        (acc_go && !pwrite && hit_div) |=> (prdata_r[31:7] == 25'h0))
        else $error("divider top bit not zero");
    AST_RATE_FAST: assert property (@(posedge pclk) disable iff (!presetn)
        (div_rise && seen_r && div_r >= `DIV_MIN) |-> (gap_r == exp_per))
        else $error("master period not divisor plus one");
    AST_RATE_SLOW: assert property (@(posedge pclk) disable iff (!presetn)
        (div_rise && seen_r && div_r < `DIV_MIN)
        |-> (gap_r == `DIV_SLOW_PERIOD))
        else $error("master period not four");
    AST_ONE_BIT: assert property (@(posedge pclk) disable iff (!presetn)
        (take && st_r == X_RUN && !last_bit) |=> (bits_r == $past(bits_r) + 4'h1))
        else $error("bit count not one per clock");
    AST_SLAVE_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
        (!ctrl_r.master && !$past(ctrl_r.master)) |=> (!sclk_out && !sclk_oe))
        else $error("slave drove serial clock");
    AST_MASTER_OE: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_r.master |=> sclk_oe)
        else $error("master not driving clock pin");
    AST_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
        (done_ev && ctrl_r.master) |=> (flag_r && rxbuf_r == $past(shift_r)))
        else $error("character not loaded with flag");
    AST_MIRROR: assert property (@(posedge pclk) disable iff (!presetn)
        (acc_go && !pwrite && hit_mir)
        |=> (prdata_r[15:0] == $past(rxbuf_r)))
        else $error("mirror differs from buffer");
    AST_MIR_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_done && hit_mir && !done_ev) |=> (flag_r == $past(flag_r)))
        else $error("mirror read changed flag");
    AST_BUF_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_done && hit_buf && !done_ev) |=> !flag_r)
        else $error("buffer read did not clear flag");
    AST_SLAVE_LOAD: assert property (
        @(posedge pclk) disable iff (!presetn)
        (done_ev && !ctrl_r.master) |=> (flag_r && rxbuf_r == $past(char_w)))
        else $error("slave character not loaded with flag");
    AST_MASTER_END: assert property (
        @(posedge pclk) disable iff (!presetn)
        (done_ev && ctrl_r.master) |=> (st_r == X_IDLE && !sclk_out))
        else $error("master clock not idle after last bit");
endmodule // spi_baud_and_rx_mirror

`default_nettype wire

/* src/spi_baud_map.svh */
// Register indices, field positions and reset values of the bit-rate
// generator and receive mirror. Definitions only; included by name.
`ifndef SPI_BAUD_MAP_SVH
`define SPI_BAUD_MAP_SVH

// Register indices; the APB byte address is four times the index
`define IDX_DIVIDER 16'h7044
`define IDX_MIRROR 16'h7046
`define IDX_RXBUF 16'h7047
`define IDX_CTRL 16'h7050
`define IDX_STATUS 16'h7051
`define IDX_INT_STS 16'h7052
`define IDX_INT_CLR 16'h7053
`define IDX_INT_EN 16'h7054
`define ADDR_W 18

// Divider field and its special range
`define DIV_W 7
`define DIV_MIN 7'h03
`define DIV_SLOW_PERIOD 8'h04
`define DIV_RST 7'h00

// Control register fields
`define CTRL_MASTER 0
`define CTRL_START 1
`define CTRL_LEN_LO 4
`define CTRL_LEN_HI 7

// Status and event bit positions
`define STS_FLAG 6
`define EV_CHAR 0
`define EV_OVR 1
`define EV_W 2

// Reset values
`define WORD_RST 16'h0000
`define LEN_RST 4'hF

// Fewest peripheral clocks per external serial clock period
`define SLAVE_RATIO 4

`endif

/* src/spi_baud_pkg.sv */
// Types shared by the bit-rate generator and receive mirror.
// Assumes the map header is compiled alongside.
package spi_baud_pkg;

    // Software-set control fields
    typedef struct packed {
        logic [3:0] len_m1; // Character length minus one
        logic master;       // 1: drive the serial clock
    } ctrl_t;

    // Receive sequencer states
    typedef enum logic [0:0] {
        X_IDLE = 1'b0,
        X_RUN = 1'b1
    } xfer_t;

endpackage

/* tb/spi_baud_and_rx_mirror_tb_top.sv */
// Self-checking bench: APB driver, far-side model, output watchers.
// Assumes the map header and package are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "spi_baud_map.svh"

module spi_baud_and_rx_mirror_tb_top;
    typedef struct packed {
        logic [31:0] d; // Expected read data
        logic e;        // Expected error
        logic c;        // Data is compared
    } note_t;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, sclk_in, sclk_out, sclk_oe, sdi, irq, busy;
    logic [`ADDR_W-1:0] paddr = '0; // Byte address
    logic [31:0] pwdata = 32'h0, prdata, r, w;
    logic pready, pslverr, p_start = 1'b0, p_master = 1'b0;
    logic [3:0] p_half = 4'h2;      // Model half period
    logic [15:0] p_word = 16'h0000; // Model character
    logic [4:0] p_len = 5'h10;      // Model length
    int failures = 0, num_checks = 0, seed = 32'h4D38;
    int cnt = 0, rises = 0, exp_period = 0, i;
    logic sclk_prev = 1'b0;  // Clock pin one cycle ago
    bit in_slave = 0;        // Pin must stay quiet
    note_t exp_q[$], note;   // Notes of pending answers
    logic [6:0] divs[6] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h7F};
    logic [4:0] lens[6] = '{5'h10, 5'h08, 5'h02, 5'h05, 5'h03, 5'h04};

    spi_baud_and_rx_mirror spi_baud_and_rx_mirror_inst (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sclk_in(sclk_in),
        .sclk_out(sclk_out), .sclk_oe(sclk_oe), .sdi(sdi), .irq(irq));
    spi_far_end_model spi_far_end_model_inst (.pclk(pclk),
        .start(p_start), .as_master(p_master), .half(p_half),
        .word(p_word), .len(p_len), .sclk_out(sclk_out),
        .sclk_in(sclk_in), .sdi(sdi), .busy(busy));

    initial begin
        forever #4 pclk = ~pclk;
    end

    task automatic tally_and_finish();
        if (failures == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] want);
        num_checks++;
        if (got !== want) begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, want);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic want);
        cmp_word({31'h0, got}, {31'h0, want});
    endtask

    // One APB transfer, then one idle edge so the next setup is clean
    task automatic apb(input logic wr, input logic [15:0] idx,
        input logic [31:0] wd, input logic [31:0] want, input logic chk,
        input logic err);
        int n;
        exp_q.push_back(note_t'{want, err, chk});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (pready !== 1'b1) begin
            failures++;
            tally_and_finish();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [15:0] idx, input logic [31:0] want);
        apb(1'b0, idx, 32'h0, want, 1'b1, 1'b0);
    endtask
    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d, 32'h0, 1'b0, 1'b0);
    endtask

    // Arm the far side with one character
    task automatic arm(input logic m, input logic [15:0] d,
        input logic [4:0] len);
        p_master <= m;
        p_word <= d;
        p_len <= len;
        p_start <= 1'b1;
        @(posedge pclk);
        p_start <= 1'b0;
        @(posedge pclk);
    endtask
    // Bounded wait for the character to finish on the wire
    task automatic wait_done();
        int n;
        n = 0;
        while (busy === 1'b1 && n < 5000) begin
            @(posedge pclk);
            n++;
        end
        if (busy !== 1'b0) begin
            failures++;
            tally_and_finish();
        end
        repeat (3) @(posedge pclk);
    endtask

    // Master character: rate, bit count, flag and both read addresses
    task automatic master_xfer(input logic [6:0] div, input logic [4:0] len);
        logic [31:0] d;
        d = $random(seed) & ((32'h1 << len) - 32'h1);
        wr(`IDX_DIVIDER, {25'h0, div});
        arm(1'b0, d[15:0], len);
        rises = 0;
        exp_period = (div < `DIV_MIN) ? 4 : div + 1;
        wr(`IDX_CTRL, {24'h0, len[3:0] - 4'h1, 4'h3});
        wait_done();
        cmp_word(rises, {27'h0, len});
        cmp_bit(irq, 1'b1);
        rd(`IDX_STATUS, 32'h40);
        rd(`IDX_MIRROR, d);
        rd(`IDX_STATUS, 32'h40);
        rd(`IDX_RXBUF, d);
        rd(`IDX_STATUS, 32'h0);
        wr(`IDX_INT_CLR, 32'h3);
        repeat (2) @(posedge pclk);
        cmp_bit(irq, 1'b0);
    endtask

    // Answers in request order, taken when pready shows
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                cmp_bit(1'b1, 1'b0);
            end else begin
                note = exp_q.pop_front();
                cmp_bit(pslverr, note.e);
                if (note.c) cmp_word(prdata, note.d);
            end
        end
    end

    // Serial clock watcher: period between rising edges, pin drive
    always @(posedge pclk) begin
        if (sclk_out === 1'b1 && sclk_prev === 1'b0) begin
            cmp_bit(sclk_oe, 1'b1);
            if (rises != 0) cmp_word(cnt, exp_period);
            rises++;
            cnt = 1;
        end else begin
            cnt++;
        end
        sclk_prev = sclk_out;
        if (in_slave)
            cmp_word({30'h0, sclk_oe, sclk_out}, 32'h0);
    end

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`IDX_DIVIDER, 32'h0);
        rd(`IDX_MIRROR, 32'h0);
        rd(`IDX_RXBUF, 32'h0);
        apb(1'b0, 16'h7045, 32'h0, 32'h0, 1'b1, 1'b1);
        wr(`IDX_DIVIDER, 32'hFF);
        rd(`IDX_DIVIDER, 32'h7F);
        for (i = 0; i < 4; i++) begin
            r = $random(seed);
            wr(`IDX_DIVIDER, r);
            rd(`IDX_DIVIDER, r & 32'h7F);
        end
        wr(`IDX_INT_EN, 32'h1);
        for (i = 0; i < 6; i++) master_xfer(divs[i], lens[i]);
        // Slave: divider left at a master value must not matter
        wr(`IDX_INT_EN, 32'h0);
        wr(`IDX_DIVIDER, 32'h3);
        wr(`IDX_CTRL, 32'h70);
        repeat (2) @(posedge pclk);
        in_slave = 1;
        w = $random(seed);
        arm(1'b1, w[15:0], 5'h08);
        wait_done();
        rd(`IDX_STATUS, 32'h40);
        w = $random(seed);
        p_half <= 4'h3;
        arm(1'b1, w[15:0], 5'h08);
        wait_done();
        cmp_bit(irq, 1'b0);
        rd(`IDX_INT_STS, 32'h3);
        rd(`IDX_MIRROR, w & 32'hFF);
        wr(`IDX_INT_EN, 32'h3);
        repeat (2) @(posedge pclk);
        cmp_bit(irq, 1'b1);
        wr(`IDX_INT_CLR, 32'h3);
        repeat (2) @(posedge pclk);
        cmp_bit(irq, 1'b0);
        rd(`IDX_INT_STS, 32'h0);
        tally_and_finish();
    end
endmodule // spi_baud_and_rx_mirror_tb_top
`default_nettype wire

/* tb/spi_far_end_model.sv */
// Far side of the serial link: a slave answering the block's clock in
// master mode, or a master clocking the block in slave mode.
// Assumes one pclk domain; start is a one-cycle pulse.
`timescale 1ns/1ns
`default_nettype none

module spi_far_end_model (
    input wire logic pclk,        // Peripheral clock
    input wire logic start,       // Arm one character
    input wire logic as_master,   // 1: model clocks the link
    input wire logic [3:0] half,  // Half period in pclk cycles
    input wire logic [15:0] word, // Character to send
    input wire logic [4:0] len,   // Bits per character
    input wire logic sclk_out,    // Block's clock drive
    output logic sclk_in,         // Clock seen by the block
    output logic sdi,             // Data seen by the block
    output logic busy             // Character in flight
);
    logic [4:0] left_r = 5'h00; // Bits still to send
    logic [3:0] idx_r = 4'h0;   // Bit now presented
    logic [4:0] ph_r = 5'h00;   // Phase of own clock
    logic [15:0] word_r = 16'h0000; // Held character
    logic sclk_q_r = 1'b0;      // Block's clock one cycle ago
    logic tog_r = 1'b0;         // Junk pattern while idle
    logic clk_r = 1'b0; // Own serial clock level
    logic [4:0] ph_nxt;         // Next phase

    assign busy = (left_r != 5'h00);
    // Idle line changes every cycle so no stale bit passes for data
    assign sdi = busy ? word_r[idx_r] : tog_r;
    assign ph_nxt = (ph_r == {half, 1'b0} - 5'h01) ? 5'h00 : ph_r + 5'h01;
    assign sclk_in = clk_r;

    // One bit per clock period, MSB first
    always @(posedge pclk) begin
        tog_r <= ~tog_r;
        sclk_q_r <= sclk_out;
        if (start) begin
            left_r <= len;
            idx_r <= len[3:0] - 4'h1;
            word_r <= word;
            ph_r <= 5'h00;
        end else if (busy && as_master) begin
            // Clock stays at a quarter of pclk or slower
            ph_r <= ph_nxt;
            clk_r <= (ph_nxt >= {1'b0, half});
            if (ph_nxt == 5'h00) begin
                left_r <= left_r - 5'h01;
                idx_r <= idx_r - 4'h1;
            end
        end else if (busy && sclk_q_r && !sclk_out) begin
            // Block drives the clock: next bit after its falling edge
            left_r <= left_r - 5'h01;
            idx_r <= idx_r - 4'h1;
        end
    end
endmodule // spi_far_end_model
`default_nettype wire
